// file: hdl/rtcf_pkg.sv
package rtcf_pkg;

	// ----------------------------------------------------------------
	// Register map (register indices, byte address is four times these)
	// ----------------------------------------------------------------
	localparam int              IDX_WIDTH       = 8;
	localparam int              ADDR_LSB        = 2;
	localparam logic [7:0]      IDX_CORE_STATUS = 8'h83;
	localparam logic [7:0]      IDX_POWER_CTRL  = 8'h8E;
	localparam logic [7:0]      IDX_IRQ_STATUS  = 8'h90;
	localparam logic [7:0]      IDX_IRQ_MASK    = 8'h91;
	localparam logic [7:0]      IDX_CONFIG      = 8'h92;
	localparam logic [7:0]      IDX_NONE        = 8'h00;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int              STATUS_TIMEOUT_BIT   = 4;
	localparam int              STATUS_POWERDOWN_BIT = 3;
	localparam int              PCTRL_POWERON_BIT    = 1;
	localparam int              PCTRL_BROWNOUT_BIT   = 0;
	localparam logic [7:0]      PCTRL_POR_VALUE      = 8'h01;
	localparam int              CFG_OSC_LSB          = 0;
	localparam int              CFG_PWRUP_EN_N_BIT   = 2;
	localparam int              CFG_BROWN_EN_BIT     = 3;
	localparam int              CFG_WIDTH            = 4;
	localparam logic [3:0]      CFG_RESET            = 4'h9;
	localparam int              IRQ_WIDTH            = 4;
	localparam int              IRQ_BROWNOUT         = 0;
	localparam int              IRQ_WATCHDOG         = 1;
	localparam int              IRQ_WAKE             = 2;
	localparam int              IRQ_READY            = 3;
	localparam logic [3:0]      IRQ_RESET            = 4'h0;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int              CNT_WIDTH       = 32;
	localparam longint          CLK_PERIOD_PS   = 5000;
	localparam longint          TOSC_PS         = CLK_PERIOD_PS;
	localparam longint          PWRUP_TIME_MS   = 72;
	localparam longint          PS_PER_MS       = 64'd1_000_000_000;
	localparam int              PWRUP_CYCLES    =
		int'((PWRUP_TIME_MS * PS_PER_MS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam longint          OSC_START_TOSC  = 1024;
	localparam int              OSC_START_CYCLES =
		int'((OSC_START_TOSC * TOSC_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		OSC_LOW_POWER  = 2'b00,
		OSC_CRYSTAL    = 2'b01,
		OSC_HIGH_SPEED = 2'b10,
		OSC_RES_CAP    = 2'b11
	} rtcf_osc_e;

	typedef enum logic [2:0] {
		ST_POWERUP_DELAY = 3'b000,
		ST_OSC_STARTUP   = 3'b001,
		ST_HOLD          = 3'b010,
		ST_RUN           = 3'b011,
		ST_SLEEP         = 3'b100,
		ST_WAKE          = 3'b101,
		ST_BROWNOUT      = 3'b110,
		ST_START         = 3'b111
	} rtcf_state_e;

endpackage

// file: hdl/rtcf_sequencer.sv
`timescale 1ns/10ps
`default_nettype none

module rtcf_sequencer #(
	parameter int unsigned PWRUP_CYCLES     = rtcf_pkg::PWRUP_CYCLES,
	parameter int unsigned OSC_START_CYCLES = rtcf_pkg::OSC_START_CYCLES,
	parameter logic [3:0]  CFG_POWER_ON     = rtcf_pkg::CFG_RESET
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        masterClearN,
	input  wire logic        brownoutDetect,
	input  wire logic        watchdogTimeout,
	input  wire logic        clearWatchdog,
	input  wire logic        sleepEnter,
	input  wire logic        wakeEvent,
	output logic             coreResetN,
	output logic             coreRun,
	output logic             irq,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		rtcf_pkg::rtcf_state_e        state;
		logic [31:0]                  count;
		logic                         coreResetN;
		logic                         coreRun;
		logic                         timeoutFlagN;
		logic                         powerdownFlagN;
		logic                         powerOnFlagN;
		logic                         brownoutFlagN;
		logic [3:0]                   cfgBits;
		logic [3:0]                   irqStatus;
		logic [3:0]                   irqMask;
		logic [1:0]                   pinClrSync;
		logic [1:0]                   brownSync;
		logic                         dataPhase;
		logic                         dataWrite;
		logic [7:0]                   dataIdx;
		logic [31:0]                  rdata;
	} rtcf_regs_s;

	localparam rtcf_regs_s REGS_RESET = '{
		state:          rtcf_pkg::ST_START,
		count:          32'h0000_0000,
		coreResetN:     1'b0,
		coreRun:        1'b0,
		timeoutFlagN:   1'b1,
		powerdownFlagN: 1'b1,
		powerOnFlagN:   rtcf_pkg::PCTRL_POR_VALUE[rtcf_pkg::PCTRL_POWERON_BIT],
		brownoutFlagN:  rtcf_pkg::PCTRL_POR_VALUE[rtcf_pkg::PCTRL_BROWNOUT_BIT],
		cfgBits:        CFG_POWER_ON,
		irqStatus:      rtcf_pkg::IRQ_RESET,
		irqMask:        rtcf_pkg::IRQ_RESET,
		pinClrSync:     2'h0,
		brownSync:      2'h0,
		dataPhase:      1'b0,
		dataWrite:      1'b0,
		dataIdx:        rtcf_pkg::IDX_NONE,
		rdata:          32'h0000_0000
	};

	localparam logic [31:0] PWRUP_LOAD = 32'(PWRUP_CYCLES - 1);
	localparam logic [31:0] OSC_LOAD   = 32'(OSC_START_CYCLES - 1);

	rtcf_regs_s             r;
	rtcf_regs_s             next_r;
	rtcf_pkg::rtcf_osc_e    oscMode;
	logic                   powerUpDelayEnableN;
	logic                   brownoutDetectEnable;
	logic                   clearPinHigh;
	logic                   brownNow;
	logic                   addrMapped;
	logic [3:0]             irqSet;
	logic [3:0]             irqClear;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic delayNeeded(input logic powerUp, input logic enableN);
		return !enableN || !powerUp;
	endfunction

	function automatic logic oscCountNeeded(input rtcf_pkg::rtcf_osc_e mode);
		return mode != rtcf_pkg::OSC_RES_CAP;
	endfunction

	function automatic logic coreOutOfReset(input rtcf_pkg::rtcf_state_e st);
		return st == rtcf_pkg::ST_RUN || st == rtcf_pkg::ST_SLEEP || st == rtcf_pkg::ST_WAKE;
	endfunction

	assign oscMode              = rtcf_pkg::rtcf_osc_e'(r.cfgBits[rtcf_pkg::CFG_OSC_LSB +: 2]);
	assign powerUpDelayEnableN  = r.cfgBits[rtcf_pkg::CFG_PWRUP_EN_N_BIT];
	assign brownoutDetectEnable = r.cfgBits[rtcf_pkg::CFG_BROWN_EN_BIT];
	assign clearPinHigh         = r.pinClrSync[1];
	assign brownNow             = r.brownSync[1] && brownoutDetectEnable;
	assign addrMapped           = haddr[31:10] == 22'h00_0000 && haddr[1:0] == 2'h0;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_r           = r;
		irqSet           = 4'h0;
		irqClear         = 4'h0;
		next_r.pinClrSync = {r.pinClrSync[0], masterClearN};
		next_r.brownSync = {r.brownSync[0], brownoutDetect};

		// Bus writes land first so that hardware events override them
		if (r.dataPhase && r.dataWrite) begin
			unique case (r.dataIdx)
				rtcf_pkg::IDX_POWER_CTRL: begin
					next_r.powerOnFlagN  = hwdata[rtcf_pkg::PCTRL_POWERON_BIT];
					next_r.brownoutFlagN = hwdata[rtcf_pkg::PCTRL_BROWNOUT_BIT];
				end
				rtcf_pkg::IDX_IRQ_MASK: begin
					next_r.irqMask = hwdata[rtcf_pkg::IRQ_WIDTH-1:0];
				end
				rtcf_pkg::IDX_CONFIG: begin
					next_r.cfgBits = hwdata[rtcf_pkg::CFG_WIDTH-1:0];
				end
				default: begin
				end
			endcase
		end

		unique case (r.state)
			rtcf_pkg::ST_START: begin
				if (delayNeeded(1'b1, powerUpDelayEnableN)) begin
					next_r.state = rtcf_pkg::ST_POWERUP_DELAY;
					next_r.count = PWRUP_LOAD;
				end else if (oscCountNeeded(oscMode)) begin
					next_r.state = rtcf_pkg::ST_OSC_STARTUP;
					next_r.count = OSC_LOAD;
				end else begin
					next_r.state = rtcf_pkg::ST_HOLD;
					irqSet[rtcf_pkg::IRQ_READY] = 1'b1;
				end
			end
			rtcf_pkg::ST_POWERUP_DELAY: begin
				if (r.count != 32'h0000_0000) begin
					next_r.count = r.count - 32'h0000_0001;
				end else if (oscCountNeeded(oscMode)) begin
					next_r.state = rtcf_pkg::ST_OSC_STARTUP;
					next_r.count = OSC_LOAD;
				end else begin
					next_r.state = rtcf_pkg::ST_HOLD;
					irqSet[rtcf_pkg::IRQ_READY] = 1'b1;
				end
			end
			rtcf_pkg::ST_OSC_STARTUP: begin
				if (r.count != 32'h0000_0000) begin
					next_r.count = r.count - 32'h0000_0001;
				end else begin
					next_r.state = rtcf_pkg::ST_HOLD;
					irqSet[rtcf_pkg::IRQ_READY] = 1'b1;
				end
			end
			rtcf_pkg::ST_HOLD: begin
				if (clearPinHigh) begin
					next_r.state = rtcf_pkg::ST_RUN;
				end
			end
			rtcf_pkg::ST_RUN: begin
				if (!clearPinHigh) begin
					next_r.state = rtcf_pkg::ST_HOLD;
				end else if (watchdogTimeout) begin
					next_r.state        = rtcf_pkg::ST_HOLD;
					next_r.timeoutFlagN = 1'b0;
					irqSet[rtcf_pkg::IRQ_WATCHDOG] = 1'b1;
				end else if (sleepEnter) begin
					next_r.state          = rtcf_pkg::ST_SLEEP;
					next_r.timeoutFlagN   = 1'b1;
					next_r.powerdownFlagN = 1'b0;
				end else if (clearWatchdog) begin
					next_r.timeoutFlagN   = 1'b1;
					next_r.powerdownFlagN = 1'b1;
				end
			end
			rtcf_pkg::ST_SLEEP: begin
				if (!clearPinHigh) begin
					next_r.state          = rtcf_pkg::ST_HOLD;
					next_r.timeoutFlagN   = 1'b1;
					next_r.powerdownFlagN = 1'b0;
				end else if (watchdogTimeout || wakeEvent) begin
					if (watchdogTimeout) begin
						next_r.timeoutFlagN = 1'b0;
						irqSet[rtcf_pkg::IRQ_WATCHDOG] = 1'b1;
					end
					irqSet[rtcf_pkg::IRQ_WAKE] = 1'b1;
					if (oscCountNeeded(oscMode)) begin
						next_r.state = rtcf_pkg::ST_WAKE;
						next_r.count = OSC_LOAD;
					end else begin
						next_r.state = rtcf_pkg::ST_RUN;
					end
				end
			end
			rtcf_pkg::ST_WAKE: begin
				if (!clearPinHigh) begin
					next_r.state          = rtcf_pkg::ST_HOLD;
					next_r.timeoutFlagN   = 1'b1;
					next_r.powerdownFlagN = 1'b0;
				end else if (r.count != 32'h0000_0000) begin
					next_r.count = r.count - 32'h0000_0001;
				end else begin
					next_r.state = rtcf_pkg::ST_RUN;
				end
			end
			rtcf_pkg::ST_BROWNOUT: begin
				if (!brownNow) begin
					next_r.state = rtcf_pkg::ST_POWERUP_DELAY;
					next_r.count = PWRUP_LOAD;
				end
			end
		endcase

		// Brown-out overrides every other state
		if (brownNow) begin
			next_r.state          = rtcf_pkg::ST_BROWNOUT;
			next_r.brownoutFlagN  = 1'b0;
			next_r.timeoutFlagN   = 1'b1;
			next_r.powerdownFlagN = 1'b1;
			if (r.state != rtcf_pkg::ST_BROWNOUT) begin
				irqSet[rtcf_pkg::IRQ_BROWNOUT] = 1'b1;
			end
		end

		next_r.coreResetN = coreOutOfReset(next_r.state);
		next_r.coreRun    = next_r.state == rtcf_pkg::ST_RUN;

		// Address phase: snapshot read data, read of interrupt status clears it
		next_r.dataPhase = 1'b0;
		if (hsel && hready && htrans[1]) begin
			next_r.dataPhase = 1'b1;
			next_r.dataWrite = hwrite;
			next_r.dataIdx   = addrMapped ? haddr[9:2] : rtcf_pkg::IDX_NONE;
			next_r.rdata     = 32'h0000_0000;
			if (!hwrite && addrMapped) begin
				unique case (haddr[9:2])
					rtcf_pkg::IDX_CORE_STATUS: begin
						next_r.rdata[rtcf_pkg::STATUS_TIMEOUT_BIT]   = next_r.timeoutFlagN;
						next_r.rdata[rtcf_pkg::STATUS_POWERDOWN_BIT] = next_r.powerdownFlagN;
					end
					rtcf_pkg::IDX_POWER_CTRL: begin
						next_r.rdata[rtcf_pkg::PCTRL_POWERON_BIT]  = next_r.powerOnFlagN;
						next_r.rdata[rtcf_pkg::PCTRL_BROWNOUT_BIT] = next_r.brownoutFlagN;
					end
					rtcf_pkg::IDX_IRQ_STATUS: begin
						next_r.rdata[rtcf_pkg::IRQ_WIDTH-1:0] = r.irqStatus;
						irqClear = r.irqStatus;
					end
					rtcf_pkg::IDX_IRQ_MASK: begin
						next_r.rdata[rtcf_pkg::IRQ_WIDTH-1:0] = next_r.irqMask;
					end
					rtcf_pkg::IDX_CONFIG: begin
						next_r.rdata[rtcf_pkg::CFG_WIDTH-1:0] = next_r.cfgBits;
					end
					default: begin
					end
				endcase
			end
		end

		// An event in the clearing cycle stays set
		next_r.irqStatus = (r.irqStatus & ~irqClear) | irqSet;
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= REGS_RESET;
		end else begin
			r <= next_r;
		end
	end

	assign coreResetN = r.coreResetN;
	assign coreRun    = r.coreRun;
	assign irq        = |(r.irqStatus & r.irqMask);
	assign hreadyout  = 1'b1;
	assign hresp      = 1'b0;
	assign hrdata     = r.rdata;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	sequence enterOscCount;
		r.state != rtcf_pkg::ST_OSC_STARTUP ##1 r.state == rtcf_pkg::ST_OSC_STARTUP;
	endsequence
	sequence delayEnds;
		r.state == rtcf_pkg::ST_POWERUP_DELAY && r.count == 32'h0000_0000 && !brownNow;
	endsequence
	start_flags_a: assert property (
		r.state == rtcf_pkg::ST_START |-> r.timeoutFlagN && r.powerdownFlagN && !r.powerOnFlagN)
		else $error("power-on flags wrong at start");
	delay_order_a: assert property (
		delayEnds ##0 oscCountNeeded(oscMode) |=> r.state == rtcf_pkg::ST_OSC_STARTUP)
		else $error("oscillator count did not follow power-up delay");
	rc_no_delay_a: assert property (
		r.state == rtcf_pkg::ST_START && oscMode == rtcf_pkg::OSC_RES_CAP
		&& powerUpDelayEnableN && !brownNow |=> r.state == rtcf_pkg::ST_HOLD)
		else $error("start-up delay applied in resistor-capacitor mode");
	osc_count_len_a: assert property (
		enterOscCount |-> r.count == OSC_LOAD && !r.coreResetN)
		else $error("oscillator start-up count loaded wrongly");
	brown_flag_a: assert property (
		brownNow |=> !r.brownoutFlagN && r.state == rtcf_pkg::ST_BROWNOUT && !r.coreResetN)
		else $error("brown-out not recorded");
	brown_ignored_a: assert property (
		!brownoutDetectEnable && r.state != rtcf_pkg::ST_BROWNOUT
		|=> r.state != rtcf_pkg::ST_BROWNOUT)
		else $error("brown-out taken while detection disabled");
	poweron_kept_a: assert property (
		!(r.dataPhase && r.dataWrite && r.dataIdx == rtcf_pkg::IDX_POWER_CTRL)
		|=> r.powerOnFlagN == $past(r.powerOnFlagN))
		else $error("power-on flag changed without a write");
	release_now_a: assert property (
		r.state == rtcf_pkg::ST_HOLD && clearPinHigh && !brownNow |=> r.coreRun && r.coreResetN)
		else $error("execution not started on master clear release");
	sleep_clear_a: assert property (
		r.state == rtcf_pkg::ST_SLEEP && !clearPinHigh && !brownNow
		|=> r.timeoutFlagN && !r.powerdownFlagN && !r.coreResetN && !r.coreRun)
		else $error("master clear in sleep gave wrong flags");
	held_reset_a: assert property (
		!clearPinHigh |=> !r.coreRun && !r.coreResetN)
		else $error("core ran while master clear low");
	status_read_a: assert property (
		hsel && hready && htrans[1] && !hwrite && addrMapped
		&& haddr[9:2] == rtcf_pkg::IDX_CORE_STATUS
		|=> r.rdata == {27'h000_0000, r.timeoutFlagN, r.powerdownFlagN, 3'h0})
		else $error("core status read value wrong");

endmodule

`default_nettype wire

// file: sim/rtcf_sequencer_tb.sv
`timescale 1ns/10ps
`default_nettype none

module rtcf_sequencer_tb;

	// ------------------------------------------------------------
	// Setup
	// ------------------------------------------------------------
	localparam int          PW   = 20;
	localparam int          OS   = 8;
	localparam logic [31:0] A_ST = {22'h000000, rtcf_pkg::IDX_CORE_STATUS, 2'b00};
	localparam logic [31:0] A_PC = {22'h000000, rtcf_pkg::IDX_POWER_CTRL, 2'b00};
	localparam logic [31:0] A_IS = {22'h000000, rtcf_pkg::IDX_IRQ_STATUS, 2'b00};
	localparam logic [31:0] A_MK = {22'h000000, rtcf_pkg::IDX_IRQ_MASK, 2'b00};
	localparam logic [31:0] A_CF = {22'h000000, rtcf_pkg::IDX_CONFIG, 2'b00};
	localparam logic [31:0] A_NO = 32'h00000100;

	typedef struct packed {
		logic [31:0] a;
		logic        w;
		logic [31:0] d;
		logic [31:0] e;
	} rtcf_row_s;

	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        masterClearN = 1'b1;
	logic        brownoutDetect = 1'b0;
	logic        watchdogTimeout = 1'b0;
	logic        clearWatchdog = 1'b0;
	logic        sleepEnter = 1'b0;
	logic        wakeEvent = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h00000000;
	logic [1:0]  htrans = 2'b00;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 32'h00000000;
	logic        coreResetN;
	logic        coreRun;
	logic        irq;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	logic        rcRun;
	int          failCount = 0;
	int          nCompared = 0;
	int          cycles = 0;
	int          n;
	logic [31:0] rd;
	rtcf_row_s   rows [10] = '{
		'{A_IS, 1'b0, 32'h0, 32'h8}, '{A_IS, 1'b0, 32'h0, 32'h0},
		'{A_ST, 1'b0, 32'h0, 32'h18}, '{A_PC, 1'b0, 32'h0, 32'h1},
		'{A_ST, 1'b1, 32'h0, 32'h18}, '{A_PC, 1'b1, 32'h3, 32'h3},
		'{A_MK, 1'b1, 32'hF, 32'hF}, '{A_CF, 1'b0, 32'h0, 32'h9},
		'{A_NO, 1'b1, 32'hFF, 32'h0}, '{A_NO, 1'b0, 32'h0, 32'h0}};

	always #2.5 clk = ~clk;

	rtcf_sequencer #(
		.PWRUP_CYCLES    (PW),
		.OSC_START_CYCLES(OS)
	) dut (
		.clk            (clk),
		.rst_n          (rst_n),
		.masterClearN   (masterClearN),
		.brownoutDetect (brownoutDetect),
		.watchdogTimeout(watchdogTimeout),
		.clearWatchdog  (clearWatchdog),
		.sleepEnter     (sleepEnter),
		.wakeEvent      (wakeEvent),
		.coreResetN     (coreResetN),
		.coreRun        (coreRun),
		.irq            (irq),
		.hsel           (hsel),
		.haddr          (haddr),
		.htrans         (htrans),
		.hwrite         (hwrite),
		.hsize          (hsize),
		.hwdata         (hwdata),
		.hready         (hreadyout),
		.hreadyout      (hreadyout),
		.hresp          (hresp),
		.hrdata         (hrdata)
	);

	// Second copy powers up in resistor-capacitor mode with the delay disabled
	rtcf_sequencer #(
		.PWRUP_CYCLES    (PW),
		.OSC_START_CYCLES(OS),
		.CFG_POWER_ON    (4'hF)
	) dutRc (
		.clk            (clk),
		.rst_n          (rst_n),
		.masterClearN   (masterClearN),
		.brownoutDetect (brownoutDetect),
		.watchdogTimeout(watchdogTimeout),
		.clearWatchdog  (clearWatchdog),
		.sleepEnter     (sleepEnter),
		.wakeEvent      (wakeEvent),
		.coreResetN     (),
		.coreRun        (rcRun),
		.irq            (),
		.hsel           (1'b0),
		.haddr          (haddr),
		.htrans         (htrans),
		.hwrite         (hwrite),
		.hsize          (hsize),
		.hwdata         (hwdata),
		.hready         (1'b1),
		.hreadyout      (),
		.hresp          (),
		.hrdata         ()
	);

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic conclude();
		$display("counts: %0d compared, %0d wrong", nCompared, failCount);
		if (failCount == 0 && nCompared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic checkVal(input string nm, input logic [31:0] e, input logic [31:0] g);
		nCompared++;
		if (g !== e) begin
			failCount++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic checkRange(input string nm, input int lo, input int hi, input int g);
		nCompared++;
		if (g < lo || g > hi) begin
			failCount++;
			$display("wrong value %s expected %0d..%0d seen %0d", nm, lo, hi, g);
		end
	endtask

	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd,
		output logic [31:0] r);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'b10;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge clk); while (hreadyout !== 1'b1);
		r = hrdata;
		checkVal("hresp", 32'h0, {31'h0, hresp});
		checkVal("hready", 32'h1, {31'h0, hreadyout});
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask

	task automatic rdChk(input string nm, input logic [31:0] a, input logic [31:0] e);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		checkVal(nm, e, r);
	endtask

	task automatic waitRun(output int k);
		k = 0;
		do begin
			@(negedge clk);
			k++;
		end while (coreRun !== 1'b1 && k < 200);
	endtask

	task automatic pulse(input int k);
		@(posedge clk);
		case (k)
			0: watchdogTimeout <= 1'b1;
			1: clearWatchdog <= 1'b1;
			2: sleepEnter <= 1'b1;
			default: wakeEvent <= 1'b1;
		endcase
		@(posedge clk);
		{watchdogTimeout, clearWatchdog, sleepEnter, wakeEvent} <= 4'h0;
	endtask

	task automatic holdClear(input int k);
		@(posedge clk);
		masterClearN <= 1'b0;
		repeat (k) @(negedge clk);
		checkVal("coreResetN", 32'h0, {31'h0, coreResetN});
		@(posedge clk);
		masterClearN <= 1'b1;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			failCount++;
			conclude();
		end
	end

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		repeat (4) @(posedge clk);
		@(negedge clk);
		checkVal("coreResetN", 32'h0, {31'h0, coreResetN});
		checkVal("irq", 32'h0, {31'h0, irq});
		@(posedge clk);
		rst_n <= 1'b1;
		repeat (5) @(negedge clk);
		checkVal("rcRun", 32'h1, {31'h0, rcRun});
		repeat (PW - 5) @(negedge clk);
		checkVal("coreResetN", 32'h0, {31'h0, coreResetN});
		waitRun(n);
		checkRange("powerUp", OS, OS + 4, n);
		$display("test power-up done");
		foreach (rows[i]) begin
			if (rows[i].w) begin
				wr(rows[i].a, rows[i].d);
			end
			rdChk("register", rows[i].a, rows[i].e);
		end
		$display("test registers done");
		wr(A_MK, 32'hD);
		pulse(0);
		waitRun(n);
		checkRange("watchdogHold", 2, 4, n);
		rdChk("status", A_ST, 32'h08);
		rdChk("powerCtrl", A_PC, 32'h3);
		checkVal("irq", 32'h0, {31'h0, irq});
		wr(A_MK, 32'hF);
		@(negedge clk);
		checkVal("irq", 32'h1, {31'h0, irq});
		rdChk("irqStatus", A_IS, 32'h2);
		@(negedge clk);
		checkVal("irq", 32'h0, {31'h0, irq});
		holdClear(4);
		waitRun(n);
		checkRange("clearRun", 1, 6, n);
		rdChk("status", A_ST, 32'h08);
		pulse(1);
		rdChk("status", A_ST, 32'h18);
		$display("test watchdog done");
		pulse(2);
		@(negedge clk);
		checkVal("coreRun", 32'h0, {31'h0, coreRun});
		pulse(3);
		waitRun(n);
		checkRange("wake", OS, OS + 4, n);
		rdChk("irqStatus", A_IS, 32'h4);
		pulse(2);
		pulse(0);
		waitRun(n);
		rdChk("status", A_ST, 32'h00);
		pulse(1);
		pulse(2);
		holdClear(4);
		waitRun(n);
		rdChk("status", A_ST, 32'h10);
		rdChk("powerCtrl", A_PC, 32'h3);
		$display("test sleep done");
		for (int i = 0; i < 2; i++) begin
			wr(A_CF, i ? 32'h9 : 32'hB);
			wr(A_PC, 32'h3);
			rdChk("irqStatus", A_IS, i ? 32'h0 : 32'h6);
			@(posedge clk);
			brownoutDetect <= 1'b1;
			repeat (4) @(posedge clk);
			brownoutDetect <= 1'b0;
			waitRun(n);
			checkRange("brownOut", i ? PW + OS - 6 : PW - 6, i ? PW + OS + 6 : PW + OS - 2, n);
			rdChk("powerCtrl", A_PC, 32'h2);
			rdChk("status", A_ST, 32'h18);
			bus(1'b0, A_IS, 32'h0, rd);
			checkVal("irqBrownOut", 32'h1, rd & 32'h1);
		end
		wr(A_CF, 32'h1);
		@(posedge clk);
		brownoutDetect <= 1'b1;
		repeat (8) @(negedge clk);
		checkVal("coreRun", 32'h1, {31'h0, coreRun});
		@(posedge clk);
		brownoutDetect <= 1'b0;
		$display("test brown-out done");
		@(posedge clk);
		rst_n <= 1'b0;
		masterClearN <= 1'b0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		repeat (PW + OS + 20) @(negedge clk);
		checkVal("coreRun", 32'h0, {31'h0, coreRun});
		@(posedge clk);
		masterClearN <= 1'b1;
		waitRun(n);
		checkRange("lateClear", 1, 6, n);
		rdChk("status", A_ST, 32'h18);
		rdChk("powerCtrl", A_PC, 32'h1);
		$display("test held clear done");
		conclude();
	end

endmodule

`default_nettype wire
